// ==== common/iops_defs.vh ====
// constants for the i/o port with pin steering: register offsets,
// field positions and reset values.
// assumes a 32-bit apb slave with one aligned word per register.
`ifndef IOPS_DEFS_VH
`define IOPS_DEFS_VH

// register byte offsets
`define IOPS_OFF_LEVEL    12'h000
`define IOPS_OFF_LATCH    12'h004
`define IOPS_OFF_DIR      12'h008
`define IOPS_OFF_ANALOG   12'h00c
`define IOPS_OFF_PULLUP   12'h010
`define IOPS_OFF_ALTSEL   12'h014

// port shape
`define IOPS_NPINS        6
`define IOPS_INPUT_ONLY   3

// reset values
`define IOPS_DIR_RST      6'h3f
`define IOPS_ANALOG_RST   6'h37
`define IOPS_PULLUP_RST   6'h00
`define IOPS_LATCH_RST    6'h00
`define IOPS_ALTSEL_RST   8'h00

// alternate_pin_select fields
`define IOPS_SEL_OSC      0
`define IOPS_SEL_LOGIC    1
`define IOPS_SEL_TGATE    3
`define IOPS_SEL_WAVE_A   6
`define IOPS_SEL_WAVE_B   7
`define IOPS_ALTSEL_MASK  8'hcb

`endif

// ==== rtl/iops_sync.v ====
// two-flop synchroniser for a vector of pin levels.
// assumes the inputs are asynchronous to pclk.
`timescale 1ns/10ps
`default_nettype none

module iops_sync
#(
    parameter WIDTH = 6
)
(
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_q
);

    // first stage is read by the second stage only
    reg [WIDTH-1:0] meta_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule // iops_sync

`default_nettype wire

// ==== rtl/iops_pin_mux.v ====
// priority mux for one port pin: the highest enabled function wins,
// otherwise the output latch drives the pin.
// assumes source 0 has the highest priority; purely combinational.
`timescale 1ns/10ps
`default_nettype none

module iops_pin_mux
#(
    parameter NSRC = 2
)
(
    // function requests, index 0 highest
    input  wire [NSRC-1:0] fn_en,
    input  wire [NSRC-1:0] fn_data,
    // general purpose path
    input  wire            latch_bit,
    // selected level
    output reg             pin_data
);

    integer i;

    always @*
    begin
        pin_data = latch_bit;
        for (i = NSRC - 1; i >= 0; i = i - 1)
        begin
            if (fn_en[i])
                pin_data = fn_data[i];
        end
    end

endmodule // iops_pin_mux

`default_nettype wire

// ==== rtl/iops_top.v ====
// general purpose i/o port with alternate pin steering, apb register side.
// assumes pin inputs are asynchronous and peripheral signals share pclk.
//
// Notes on behaviour
// RULE_01 - port has direction, level and latch registers
// RULE_02 - enabled peripheral output replaces latch, pin readable
// RULE_03 - level register write updates the output latch
// RULE_04 - latch reads latch, level reads pin levels
// RULE_05 - analog select disables digital input buffer
// RULE_06 - steering relocates data out, select, gate, cell, osc
// RULE_07 - steering never changes direction register contents
// RULE_08 - steered function drives selected pin, other unaffected
// RULE_09 - bit 7: wave b on pin 4, else 0
// RULE_10 - bit 6: wave a on pin 5, else 2
// RULE_11 - bit 0: oscillator on pin 5, else 1
// RULE_12 - direction one is input, zero drives latch
// RULE_13 - analog pins read zero, analog after reset
// RULE_14 - highest priority enabled function owns the pin
// RULE_15 - bit 1: logic cell on pin 4, else 2
// RULE_16 - steering resets zero, unused bits read zero
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "iops_defs.vh"

module iops_top
#(
    parameter NPINS = `IOPS_NPINS
)
(
    // apb
    input  wire             pclk,
    input  wire             presetn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // package pins
    input  wire [NPINS-1:0] pin_in,
    output reg  [NPINS-1:0] pin_out,
    output reg  [NPINS-1:0] pin_oe,
    output reg  [NPINS-1:0] pin_pullup_en,
    // peripheral outputs
    input  wire             wave_gen_out_a,
    input  wire             wave_gen_out_a_en,
    input  wire             wave_gen_out_b,
    input  wire             wave_gen_out_b_en,
    input  wire             logic_cell_output,
    input  wire             logic_cell_output_en,
    input  wire             numeric_osc_output,
    input  wire             numeric_osc_output_en,
    // peripheral inputs
    output reg              timer_gate_input,
    output reg  [NPINS-1:0] digital_in
);

    ////////////////////////////////////////////////////////////////////
    // registers

    reg  [NPINS-1:0] output_latch_reg_q;
    reg  [NPINS-1:0] pin_direction_reg_q;
    reg  [NPINS-1:0] analog_select_reg_q;
    reg  [NPINS-1:0] weak_pullup_reg_q;
    reg  [7:0]       alternate_pin_select_q;
    // next values
    reg  [NPINS-1:0] output_latch_reg_d;
    reg  [NPINS-1:0] pin_direction_reg_d;
    reg  [NPINS-1:0] analog_select_reg_d;
    reg  [NPINS-1:0] weak_pullup_reg_d;
    reg  [7:0]       alternate_pin_select_d;
    // read answer
    reg  [31:0]      rdata_d;
    reg              rderr_d;
    // pin drive
    reg              tgate_d;
    wire [NPINS-1:0] oe_d;
    wire [NPINS-1:0] pullup_d;
    wire [NPINS-1:0] pin_sync;
    wire [NPINS-1:0] din_d;
    wire             wr_en;
    wire             setup;

    assign wr_en = psel & penable & pwrite;
    // a setup may follow an access at once; pready answers it next cycle
    assign setup = psel & ~penable;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_latch_reg_q     <= `IOPS_LATCH_RST;
            pin_direction_reg_q    <= `IOPS_DIR_RST;
            analog_select_reg_q    <= `IOPS_ANALOG_RST;              // RULE_13
            weak_pullup_reg_q      <= `IOPS_PULLUP_RST;
            alternate_pin_select_q <= `IOPS_ALTSEL_RST;              // RULE_16
        end
        else
        begin
            output_latch_reg_q     <= output_latch_reg_d;
            pin_direction_reg_q    <= pin_direction_reg_d;            // RULE_01
            analog_select_reg_q    <= analog_select_reg_d;
            weak_pullup_reg_q      <= weak_pullup_reg_d;
            alternate_pin_select_q <= alternate_pin_select_d;
        end
    end

    // next register values; a write lands only in the access phase
    always @*
    begin
        output_latch_reg_d     = output_latch_reg_q;
        pin_direction_reg_d    = pin_direction_reg_q;
        analog_select_reg_d    = analog_select_reg_q;
        weak_pullup_reg_d      = weak_pullup_reg_q;
        alternate_pin_select_d = alternate_pin_select_q;
        if (wr_en)
        begin
            case (paddr)
                // level and latch offsets share one store
                `IOPS_OFF_LEVEL,
                `IOPS_OFF_LATCH:
                    output_latch_reg_d = pwdata[NPINS-1:0];          // RULE_03
                `IOPS_OFF_DIR:
                    // input-only pin keeps its direction bit set
                    pin_direction_reg_d = pwdata[NPINS-1:0] | (6'h01 << `IOPS_INPUT_ONLY);
                `IOPS_OFF_ANALOG:
                    analog_select_reg_d = pwdata[NPINS-1:0];
                `IOPS_OFF_PULLUP:
                    weak_pullup_reg_d = pwdata[NPINS-1:0];
                `IOPS_OFF_ALTSEL:
                    // steering writes touch nothing but routing
                    alternate_pin_select_d = pwdata[7:0] & `IOPS_ALTSEL_MASK; // RULE_07 RULE_16
                default:
                    ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb answer: zero wait states, data prepared in the setup cycle

    // read decode; unmapped offsets refuse with a slave error
    always @*
    begin
        rdata_d = 32'h0000_0000;
        rderr_d = 1'b0;
        case (paddr)
            // level offset reads the pins, latch offset reads the store
            `IOPS_OFF_LEVEL:
                rdata_d = {26'h0, din_d};                             // RULE_04
            `IOPS_OFF_LATCH:
                rdata_d = {26'h0, output_latch_reg_q};                // RULE_04
            `IOPS_OFF_DIR:
                rdata_d = {26'h0, pin_direction_reg_q};               // RULE_01
            `IOPS_OFF_ANALOG:
                rdata_d = {26'h0, analog_select_reg_q};
            `IOPS_OFF_PULLUP:
                rdata_d = {26'h0, weak_pullup_reg_q};
            `IOPS_OFF_ALTSEL:
                rdata_d = {24'h0, alternate_pin_select_q};
            default:
                rderr_d = 1'b1;
        endcase
    end

    // level reads use the value synchronised at the setup edge,
    // so a pin change shows three edges later at the earliest
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & rderr_d;
            prdata  <= setup ? rdata_d : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // input path

    iops_sync
    #(
        .WIDTH (NPINS)
    )
    u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in),
        .sync_q   (pin_sync)
    );

    // analog pins gate the digital buffer off, so they read zero
    // and a half-level input reaches only the synchroniser in front of the gate
    assign din_d = pin_sync & ~analog_select_reg_q;                   // RULE_05 RULE_13

    ////////////////////////////////////////////////////////////////////
    // output steering; each function enable is qualified by its select bit

    wire sel_b  = alternate_pin_select_q[`IOPS_SEL_WAVE_B];
    wire sel_a  = alternate_pin_select_q[`IOPS_SEL_WAVE_A];
    wire sel_lc = alternate_pin_select_q[`IOPS_SEL_LOGIC];
    wire sel_os = alternate_pin_select_q[`IOPS_SEL_OSC];
    wire sel_tg = alternate_pin_select_q[`IOPS_SEL_TGATE];

    wire [NPINS-1:0] mux_out;

    // pin 0: wave b when not steered away
    iops_pin_mux #(.NSRC(1)) u_mux0
    (
        .fn_en     (wave_gen_out_b_en & ~sel_b),                      // RULE_09
        .fn_data   (wave_gen_out_b),
        .latch_bit (output_latch_reg_q[0]),
        .pin_data  (mux_out[0])
    );

    // pin 1: oscillator on its default pin
    iops_pin_mux #(.NSRC(1)) u_mux1
    (
        .fn_en     (numeric_osc_output_en & ~sel_os),                 // RULE_11
        .fn_data   (numeric_osc_output),
        .latch_bit (output_latch_reg_q[1]),
        .pin_data  (mux_out[1])
    );

    // pin 2: wave a above logic cell
    iops_pin_mux #(.NSRC(2)) u_mux2
    (
        .fn_en     ({logic_cell_output_en & ~sel_lc, wave_gen_out_a_en & ~sel_a}), // RULE_10 RULE_15 RULE_14
        .fn_data   ({logic_cell_output, wave_gen_out_a}),
        .latch_bit (output_latch_reg_q[2]),
        .pin_data  (mux_out[2])
    );

    // pin 3 is input only
    assign mux_out[3] = output_latch_reg_q[3];

    // pin 4: wave b above logic cell on their alternate pin
    iops_pin_mux #(.NSRC(2)) u_mux4
    (
        .fn_en     ({logic_cell_output_en & sel_lc, wave_gen_out_b_en & sel_b}), // RULE_09 RULE_15 RULE_14
        .fn_data   ({logic_cell_output, wave_gen_out_b}),
        .latch_bit (output_latch_reg_q[4]),
        .pin_data  (mux_out[4])
    );

    // pin 5: wave a above oscillator on their alternate pin
    iops_pin_mux #(.NSRC(2)) u_mux5
    (
        .fn_en     ({numeric_osc_output_en & sel_os, wave_gen_out_a_en & sel_a}), // RULE_10 RULE_11 RULE_14
        .fn_data   ({numeric_osc_output, wave_gen_out_a}),
        .latch_bit (output_latch_reg_q[5]),
        .pin_data  (mux_out[5])
    );

    ////////////////////////////////////////////////////////////////////
    // next pin drive values

    // a peripheral that owns a pin still needs the direction bit cleared
    // before it reaches the pad; pull-ups act on inputs only
    assign oe_d     = ~pin_direction_reg_q;                           // RULE_12
    assign pullup_d = weak_pullup_reg_q & pin_direction_reg_q;

    // gate input: pin 3 when selected, else pin 4; the pin left behind
    // keeps its ordinary input behaviour
    always @*
    begin
        if (sel_tg)
            tgate_d = din_d[3];                                       // RULE_06 RULE_08
        else
            tgate_d = din_d[4];
    end

    ////////////////////////////////////////////////////////////////////
    // registered pin drive and peripheral inputs

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out          <= {NPINS{1'b0}};
            pin_oe           <= {NPINS{1'b0}};
            pin_pullup_en    <= {NPINS{1'b0}};
            timer_gate_input <= 1'b0;
            digital_in       <= {NPINS{1'b0}};
        end
        else
        begin
            // every pad-facing output leaves a flop so the pins never glitch
            pin_out          <= mux_out;                              // RULE_02 RULE_08
            pin_oe           <= oe_d;                                 // RULE_12
            pin_pullup_en    <= pullup_d;
            timer_gate_input <= tgate_d;
            digital_in       <= din_d;                                // RULE_02
        end
    end

endmodule // iops_top

`default_nettype wire

// ==== bench/iops_top_props.sv ====
// checker for iops_top: apb answer, pin drive and steering.
// assumes a bind to iops_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module iops_top_props
#(
    parameter NPINS = 6
)
(
    // apb
    input wire logic             pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata, prdata,
    // pins and peripherals
    input wire logic [NPINS-1:0] pin_out, pin_oe, pin_pullup_en,
    input wire logic             wave_gen_out_a, wave_gen_out_a_en, wave_gen_out_b, wave_gen_out_b_en,
    input wire logic             logic_cell_output, logic_cell_output_en,
    input wire logic             numeric_osc_output, numeric_osc_output_en
);
    logic [7:0] sel_q;
    logic       wr;
    assign wr = psel && penable && pwrite;
    // shadow of the steering register, unused bits dropped
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            sel_q <= 8'h00;
        else if (wr && paddr == 12'h014)
            sel_q <= pwdata[7:0] & 8'hcb;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_access: assert property (psel && !penable |=> pready) else $error("no ready in access");
    a_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("data outside access");
    a_unmapped_err: assert property (psel && !penable && paddr > 12'h014 |=> pslverr) else $error("no refusal");
    a_input_only: assert property (!pin_oe[3] && (pin_pullup_en & pin_oe) == '0) else $error("bad drive");
    a_steer_dir: assert property (wr && paddr == 12'h014 |=> ##1 $stable(pin_oe)) else $error("oe moved");
    a_wave_b: assert property (wave_gen_out_b_en && sel_q[7] |=> pin_out[4] == $past(wave_gen_out_b))
        else $error("wave b not on pin 4");
    a_wave_a: assert property (wave_gen_out_a_en && sel_q[6] |=> pin_out[5] == $past(wave_gen_out_a))
        else $error("wave a not on pin 5");
    a_osc_pin1: assert property (numeric_osc_output_en && !sel_q[0] |=> pin_out[1] == $past(numeric_osc_output))
        else $error("osc not on pin 1");
    a_cell_pin4: assert property (logic_cell_output_en && sel_q[1] && !(wave_gen_out_b_en && sel_q[7])
        |=> pin_out[4] == $past(logic_cell_output)) else $error("cell not on pin 4");
endmodule // iops_top_props
bind iops_top iops_top_props #(.NPINS(NPINS)) u_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .pslverr, .paddr, .pwdata, .prdata, .pin_out, .pin_oe, .pin_pullup_en, .wave_gen_out_a, .wave_gen_out_a_en,
    .wave_gen_out_b, .wave_gen_out_b_en, .logic_cell_output, .logic_cell_output_en, .numeric_osc_output,
    .numeric_osc_output_en);
`default_nettype wire

// ==== bench/iops_far_side.sv ====
// package pins seen from outside the port.
// assumes the bench sets the outside level of released pins.
`timescale 1ns/10ps
`default_nettype none
module iops_far_side
#(
    parameter NPINS = 6
)
(
    // port side
    input wire logic [NPINS-1:0] pin_out, pin_oe, pin_pullup_en,
    // outside world
    input wire logic [NPINS-1:0] ext_lvl,
    output logic     [NPINS-1:0] pin_in
);
    // a driven pin wins over the outside; a pull-up beats a floating level
    always_comb
        for (int i = 0; i < NPINS; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pullup_en[i] ? 1'b1 : ext_lvl[i]);
endmodule // iops_far_side
`default_nettype wire

// ==== bench/tb_iops_top.sv ====
// self-checking bench for iops_top over apb.
// assumes iops_far_side closes the pins and peripherals share pclk.
`timescale 1ns/10ps
`default_nettype none
module tb_iops_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, tgate;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [5:0]  pin_in, pin_out, pin_oe, pin_pu, digital_in, ext_lvl = '0;
    logic [3:0]  fen = '0, fval = '0;
    int          fails = 0, n_tests = 0, cyc = 0;
    always #5 pclk = ~pclk;
    iops_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pin_in, .pin_out, .pin_oe, .pin_pullup_en(pin_pu), .wave_gen_out_a(fval[0]), .wave_gen_out_a_en(fen[0]),
        .wave_gen_out_b(fval[1]), .wave_gen_out_b_en(fen[1]), .logic_cell_output(fval[2]),
        .logic_cell_output_en(fen[2]), .numeric_osc_output(fval[3]), .numeric_osc_output_en(fen[3]),
        .timer_gate_input(tgate), .digital_in);
    iops_far_side i_far (.pin_out, .pin_oe, .pin_pullup_en(pin_pu), .ext_lvl, .pin_in);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rchk(string what, logic [11:0] a, logic [31:0] exp);
        apb(0, a, 0);
        chk(what, rd, exp);
    endtask
    // latch 0x2a under whichever function owns each pin
    function automatic logic [5:0] exp_out(logic [7:0] s, logic [3:0] en, logic [3:0] v);
        logic [5:0] e;
        e = 6'h2a;
        if (en[1] && !s[7]) e[0] = v[1];
        if (en[3] && !s[0]) e[1] = v[3];
        if (en[0] && !s[6]) e[2] = v[0];
        else if (en[2] && !s[1]) e[2] = v[2];
        if (en[1] && s[7]) e[4] = v[1];
        else if (en[2] && s[1]) e[4] = v[2];
        if (en[0] && s[6]) e[5] = v[0];
        else if (en[3] && s[0]) e[5] = v[3];
        return e;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        ext_lvl <= 6'h3f;
        rchk("latch", 12'h004, 32'h0);
        rchk("direction", 12'h008, 32'h3f);
        rchk("analog", 12'h00c, 32'h37);
        rchk("steering", 12'h014, 32'h0);
        rchk("level", 12'h000, 32'h08);
        chk("digital_in", digital_in, 32'h08);
        rchk("unmapped data", 12'h018, 32'h0);
        chk("unmapped err", err, 1);
    endtask
    task automatic t_latch;
        apb(1, 12'h00c, 32'h0);
        apb(1, 12'h008, 32'h0);
        apb(1, 12'h000, 32'hffffff15);
        rchk("latch via level", 12'h004, 32'h15);
        apb(1, 12'h004, 32'h2a);
        rchk("latch", 12'h004, 32'h2a);
        ext_lvl <= 6'h00;
        repeat (4) @(posedge pclk);
        chk("pin_oe", pin_oe, 32'h37);
        rchk("level", 12'h000, 32'h22);
    endtask
    task automatic t_analog;
        apb(1, 12'h00c, 32'h3f);
        repeat (4) @(posedge pclk);
        chk("digital_in analog", digital_in, 32'h0);
        rchk("level analog", 12'h000, 32'h0);
        apb(1, 12'h00c, 32'h0);
    endtask
    task automatic t_steer;
        apb(1, 12'h014, 32'hff);
        rchk("steering mask", 12'h014, 32'hcb);
        chk("pin_oe kept", pin_oe, 32'h37);
        for (int s = 0; s < 2; s++)
        begin
            apb(1, 12'h014, s ? 32'hcb : 32'h0);
            for (int k = 0; k < 256; k++)
            begin
                fen <= k[3:0];
                fval <= k[7:4];
                repeat (2) @(posedge pclk);
                chk("pin_out", pin_out & 6'h37, exp_out(s ? 8'hcb : 8'h0, k[3:0], k[7:4]) & 6'h37);
            end
        end
        fen <= 4'h0;
    endtask
    task automatic t_gate;
        apb(1, 12'h008, 32'h3f);
        ext_lvl <= 6'h08;
        apb(1, 12'h014, 32'h08);
        repeat (4) @(posedge pclk);
        chk("gate on pin 3", tgate, 1);
        apb(1, 12'h014, 32'h0);
        repeat (4) @(posedge pclk);
        chk("gate on pin 4", tgate, 0);
        apb(1, 12'h010, 32'h3f);
        rchk("pullup", 12'h010, 32'h3f);
        chk("pin_pullup_en", pin_pu, 32'h3f);
        rchk("level pulled", 12'h000, 32'h3f);
        apb(1, 12'h008, 32'h0);
        repeat (2) @(posedge pclk);
        chk("pullup on inputs", pin_pu, 32'h08);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // run is about 1130 cycles; the ceiling leaves ample room
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            summarize();
        end
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_latch();
        t_analog();
        t_steer();
        t_gate();
        summarize();
    end
endmodule // tb_iops_top
`default_nettype wire
